// ==== logic/pwm_timer_pkg.sv ====
// constants, register map and carrier types of the auto-reload pwm timer
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`default_nettype none
package pwm_timer_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_DUTY3 = 8'h74;
  localparam logic [7:0] IDX_DUTY2 = 8'h75;
  localparam logic [7:0] IDX_DUTY1 = 8'h76;
  localparam logic [7:0] IDX_DUTY0 = 8'h77;
  localparam logic [7:0] IDX_OE_POL = 8'h78;
  localparam logic [7:0] IDX_CSR = 8'h79;
  localparam logic [7:0] IDX_CAR = 8'h7a;
  localparam logic [7:0] IDX_RELOAD = 8'h7b;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h7f;
  // control/status field positions
  localparam int CSR_OVF_BIT = 0;
  localparam int CSR_OIE_BIT = 1;
  localparam int CSR_FORCE_BIT = 2;
  localparam int CSR_RUN_BIT = 3;
  localparam int CSR_PSC_LSB = 4;
  // reset values and counter top
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_PSC = 7'h00;
  localparam logic [7:0] CNT_TOP = 8'hff;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // enable and polarity register layout
  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] pol;
  } oe_pol_t;

  // control fields of the control/status register
  typedef struct packed {
    logic [2:0] psc_sel;
    logic run;
    logic overflow_irq_enable;
  } tmr_ctrl_t;
endpackage
`default_nettype wire

// ==== logic/pwm_prescaler.sv ====
// power-of-two prescaler producing the counter tick
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic clear,
  input wire logic [2:0] sel,
  // tick to the counter
  output logic tick
);
  import pwm_timer_pkg::*;
  logic [6:0] psc_r;
  logic [6:0] mask;

  // tick when all bits below the selected ratio are ones
  assign mask = 7'((8'h01 << sel) - 8'h01);
  assign tick = run && ((psc_r & mask) == mask);

  // frozen when stopped, zeroed by a forced reload
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      psc_r <= RST_PSC;
    end else if (clear) begin
      psc_r <= RST_PSC;
    end else if (run) begin
      psc_r <= psc_r + 7'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a ratio change by software may legally tick on the next clock
  a_tick_spacing: assert property ((tick && sel != 3'h0 && !clear) ##1 $stable(sel) |-> !tick)
    else $error("prescaler ticked twice in a row");
endmodule // pwm_prescaler
`default_nettype wire

// ==== logic/pwm_channel.sv ====
// one pwm channel: compare latch and output stage
`timescale 1ns/1ps
`default_nettype none
module pwm_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // timer state
  input wire logic [7:0] cnt,
  input wire logic ovf_evt,
  // channel settings
  input wire logic [7:0] duty,
  input wire logic oe,
  input wire logic pol,
  // pin
  output logic pwm_out
);
  import pwm_timer_pkg::*;
  logic [7:0] cmp_r;

  // duty only reaches the compare at a period boundary, so no glitch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_r <= RST_BYTE;
    end else if (ovf_evt) begin
      cmp_r <= duty;
    end
  end

  // polarity is applied live, not latched, so a change shows next edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= oe && ((cnt <= cmp_r) ^ pol);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_oe_gates_pin: assert property (!oe |=> !pwm_out)
    else $error("disabled channel drives its pin");
  a_pol_level: assert property (oe |=> pwm_out == ($past(cnt <= cmp_r) ^ $past(pol)))
    else $error("pwm level does not follow compare and polarity");
  a_cmp_latch: assert property (ovf_evt |=> cmp_r == $past(duty))
    else $error("compare did not take duty at overflow");
endmodule // pwm_channel
`default_nettype wire

// ==== logic/pwm_timer_top.sv ====
// auto-reload pwm timer with four outputs behind an axi4-lite slave
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_top #(
  parameter int ADDR_W = 12,
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_B,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  // axi4-lite write data
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  // axi4-lite read data
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // interrupt and pins
  output logic IRQ,
  output logic [NUM_CH-1:0] PWM_OUT
);
  import pwm_timer_pkg::*;

  // ---------------------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------------------
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must cover the register indices");
  end
  if (NUM_CH != 4) begin : g_bad_ch
    $error("register layout serves exactly four channels");
  end

  // word index of a byte address
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[9:2];
  endfunction

  // index lies inside the register map
  function automatic logic idx_mapped(input logic [7:0] i);
    idx_mapped = (i >= IDX_DUTY3 && i <= IDX_RELOAD) || i == IDX_IRQ_MASK;
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [7:0] duty_r [NUM_CH];
  oe_pol_t oe_pol_r;
  tmr_ctrl_t ctrl_r;
  logic ovf_r;
  logic irq_mask_r;
  logic [7:0] cnt_r;
  logic [7:0] reload_r;
  logic awready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic tick;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic wr_do;
  logic wr_en;
  logic rd_do;
  logic car_wr;
  logic force_wr;
  logic ovf_evt;
  logic csr_read;
  logic [7:0] rd_byte;

  // ---------------------------------------------------------------------------
  // axi4-lite handshakes
  // ---------------------------------------------------------------------------
  assign wr_idx = word_idx(AWADDR);
  assign rd_idx = word_idx(ARADDR);
  // address and data are taken together at the edge where awready_r is high
  assign wr_do = awready_r;
  assign wr_en = wr_do && WSTRB[0] && idx_mapped(wr_idx);
  assign rd_do = arready_r;

  // write address/data ready: one-cycle pulse once both are offered
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      awready_r <= 1'b0;
    end else begin
      awready_r <= AWVALID && WVALID && !awready_r && !bvalid_r;
    end
  end

  // write response held until the master takes it
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // read address ready: one read in flight at a time
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      arready_r <= 1'b0;
    end else begin
      arready_r <= ARVALID && !arready_r && !rvalid_r;
    end
  end

  // read mux; unused bits of the control/status byte read zero
  always_comb begin
    rd_byte = RST_BYTE;
    case (rd_idx)
      IDX_DUTY3: rd_byte = duty_r[3];
      IDX_DUTY2: rd_byte = duty_r[2];
      IDX_DUTY1: rd_byte = duty_r[1];
      IDX_DUTY0: rd_byte = duty_r[0];
      IDX_OE_POL: rd_byte = oe_pol_r;
      IDX_CSR: rd_byte = {1'b0, ctrl_r.psc_sel, ctrl_r.run, 1'b0, ctrl_r.overflow_irq_enable, ovf_r};
      IDX_CAR: rd_byte = cnt_r;
      IDX_RELOAD: rd_byte = reload_r;
      IDX_IRQ_MASK: rd_byte = {7'h00, irq_mask_r};
      default: rd_byte = RST_BYTE;
    endcase
  end

  // read data held until the master takes it
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (rd_do) begin
      rvalid_r <= 1'b1;
      rresp_r <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_r <= {24'h00_0000, rd_byte};
    end else if (RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------------
  // duty registers, one per channel
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < NUM_CH; i++) begin
        duty_r[i] <= RST_BYTE;
      end
    end else if (wr_en) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_idx == 8'(IDX_DUTY0 - 8'(i))) begin
          duty_r[i] <= WDATA[7:0];
        end
      end
    end
  end

  // enable/polarity, reload value and control fields
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      oe_pol_r <= RST_BYTE;
      reload_r <= RST_BYTE;
      ctrl_r <= '0;
      irq_mask_r <= 1'b0;
    end else if (wr_en) begin
      case (wr_idx)
        IDX_OE_POL: oe_pol_r <= WDATA[7:0];
        IDX_RELOAD: reload_r <= WDATA[7:0];
        IDX_CSR: begin
          ctrl_r.psc_sel <= WDATA[CSR_PSC_LSB +: 3];
          ctrl_r.run <= WDATA[CSR_RUN_BIT];
          ctrl_r.overflow_irq_enable <= WDATA[CSR_OIE_BIT];
        end
        IDX_IRQ_MASK: irq_mask_r <= WDATA[0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------------
  assign car_wr = wr_en && wr_idx == IDX_CAR;
  assign force_wr = wr_en && wr_idx == IDX_CSR && WDATA[CSR_FORCE_BIT];
  // a software load in the same cycle suppresses the wrap
  assign ovf_evt = tick && cnt_r == CNT_TOP && !car_wr && !force_wr;

  pwm_prescaler u_psc (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .run(ctrl_r.run),
    .clear(force_wr),
    .sel(ctrl_r.psc_sel),
    .tick(tick)
  );

  // software writes win over counting so the loaded value is never lost
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      cnt_r <= RST_BYTE;
    end else if (car_wr) begin
      cnt_r <= WDATA[7:0];
    end else if (force_wr) begin
      cnt_r <= reload_r;
    end else if (tick) begin
      cnt_r <= (cnt_r == CNT_TOP) ? reload_r : cnt_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // overflow flag and interrupt
  // ---------------------------------------------------------------------------
  assign csr_read = rd_do && rd_idx == IDX_CSR;

  // set wins over the clear of a read in the same cycle
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ovf_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_r <= 1'b1;
    end else if (csr_read) begin
      ovf_r <= 1'b0;
    end
  end

  // level interrupt, one cycle behind the flag
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ovf_r && ctrl_r.overflow_irq_enable && irq_mask_r;
    end
  end

  // ---------------------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------------------
  // all channels share one counter and one overflow, hence one first edge
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    pwm_channel u_ch (
      .clk(CLK_SYS),
      .rst_b(RST_B),
      .cnt(cnt_r),
      .ovf_evt(ovf_evt),
      .duty(duty_r[c]),
      .oe(oe_pol_r.oe[c]),
      .pol(oe_pol_r.pol[c]),
      .pwm_out(PWM_OUT[c])
    );
  end

  assign AWREADY = awready_r;
  assign WREADY = awready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RRESP = rresp_r;
  assign RDATA = rdata_r;
  assign IRQ = irq_r;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence s_wrap;
    ovf_evt;
  endsequence

  a_wrap_reload: assert property (s_wrap |=> cnt_r == $past(reload_r))
    else $error("counter did not reload at overflow");
  a_wrap_flag: assert property (s_wrap |=> ovf_r)
    else $error("overflow flag not set");
  a_irq_level: assert property (IRQ == $past(ovf_r && ctrl_r.overflow_irq_enable && irq_mask_r))
    else $error("interrupt does not follow masked flag");
  a_car_write: assert property (car_wr |=> cnt_r == $past(WDATA[7:0]))
    else $error("counter write lost");
  a_force_load: assert property (force_wr && !car_wr |=> cnt_r == $past(reload_r))
    else $error("forced reload did not load counter");
  a_run_freeze: assert property (!ctrl_r.run && !car_wr && !force_wr |=> $stable(cnt_r))
    else $error("counter moved while stopped");
  a_step_up: assert property (tick && cnt_r != CNT_TOP && !car_wr && !force_wr
      |=> cnt_r == 8'($past(cnt_r) + 8'h01))
    else $error("counter did not step by one");

  // bus answers come one clock after the taking edge and stand until taken
  sequence s_wr_taken;
    awready_r;
  endsequence

  sequence s_rd_taken;
    arready_r;
  endsequence

  a_wr_resp: assert property (s_wr_taken |=> BVALID)
    else $error("write response missing after taking edge");
  a_wr_release: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response not released");
  a_rd_resp: assert property (s_rd_taken |=> RVALID && RDATA[31:8] == 24'h00_0000)
    else $error("read data missing after taking edge");
  a_rd_release: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data not released");
  a_force_zero: assert property (csr_read |=> RDATA[CSR_FORCE_BIT] == 1'b0)
    else $error("force reload bit read back as one");

  // software copies land at the taking edge
  a_reload_write: assert property (wr_en && wr_idx == IDX_RELOAD
      |=> reload_r == $past(WDATA[7:0]))
    else $error("reload value write lost");
  a_duty_write: assert property (wr_en && wr_idx == IDX_DUTY0
      |=> duty_r[0] == $past(WDATA[7:0]))
    else $error("duty write lost");

  // a read clears the flag only when no overflow lands in the same cycle
  a_flag_clear: assert property (csr_read && !ovf_evt |=> !ovf_r)
    else $error("overflow flag survived its read");
  a_flag_hold: assert property (ovf_r && !csr_read |=> ovf_r)
    else $error("overflow flag lost without a read");
  // a stopped timer never ticks, so only software writes move the counter or prescaler
  a_idle_tick: assert property (!ctrl_r.run |-> !tick)
    else $error("prescaler ticked while stopped");
endmodule // pwm_timer_top
`default_nettype wire

// ==== test/pwm_load_model.sv ====
// behavioural load on the four pwm pins: measures period and high time
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins under observation
  input wire logic [3:0] pins,
  // measurements in system clocks
  output logic [15:0] period_len [4],
  output logic [15:0] high_len [4],
  output logic [31:0] rise_at [4]
);
  logic [3:0] prev_r;
  logic [15:0] run_cnt [4];
  logic [15:0] hi_cnt [4];
  logic [31:0] now_r;

  // a rise closes one period and opens the next; loads never drive the pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 4'h0;
      now_r <= 32'h0;
      for (int c = 0; c < 4; c++) begin
        run_cnt[c] <= 16'h0;
        hi_cnt[c] <= 16'h0;
        period_len[c] <= 16'h0;
        high_len[c] <= 16'h0;
        rise_at[c] <= 32'h0;
      end
    end else begin
      prev_r <= pins;
      now_r <= now_r + 32'h1;
      for (int c = 0; c < 4; c++) begin
        if (pins[c] && !prev_r[c]) begin
          period_len[c] <= run_cnt[c] + 16'h1;
          high_len[c] <= hi_cnt[c];
          rise_at[c] <= now_r;
          run_cnt[c] <= 16'h0;
          hi_cnt[c] <= 16'h1;
        end else begin
          run_cnt[c] <= run_cnt[c] + 16'h1;
          hi_cnt[c] <= hi_cnt[c] + {15'h0, pins[c]};
        end
      end
    end
  end
endmodule // pwm_load_model
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking bench for the auto-reload pwm timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pwm_timer_pkg::*;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, pwm;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] period_len [4];
  logic [15:0] high_len [4];
  logic [31:0] rise_at [4];
  logic [7:0] rd, rd2, rl;
  logic [7:0] dt [4];
  int error_cnt, checks, seed, per;
  localparam logic [7:0] MAP [9] = '{IDX_DUTY3, IDX_DUTY2, IDX_DUTY1, IDX_DUTY0,
    IDX_OE_POL, IDX_CSR, IDX_CAR, IDX_RELOAD, IDX_IRQ_MASK};

  pwm_timer_top dut (.CLK_SYS(clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .IRQ(irq), .PWM_OUT(pwm));
  pwm_load_model load (.clk(clk), .rst_b(rst_b), .pins(pwm), .period_len(period_len),
    .high_len(high_len), .rise_at(rise_at));

  // 20 mhz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t response got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmp_len(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t length got %0d expected %0d", $time, got, exp);
    end
  endtask

  // address and data offered together, both held until the ready edge
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] val,
                           output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (awready !== 1'b1 && n < 100);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n >= 100) begin
      error_cnt++;
      $display("ERROR %0t write not answered", $time);
    end
  endtask

  task automatic axi_read(input logic [7:0] idx, output logic [7:0] val,
                          output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    val = rdata[7:0];
    resp = rresp;
    rready <= 1'b0;
    if (n >= 100) begin
      error_cnt++;
      $display("ERROR %0t read not answered", $time);
    end
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial begin
    seed = 32'h5e8008b9;
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf; // only the low lane carries data
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    // every mapped register comes out of reset at zero
    for (int i = 0; i < 9; i++) begin
      axi_read(MAP[i], rd, rs);
      cmp_byte(rd, 8'h00);
      cmp_resp(rs, RESP_OKAY);
    end
    axi_read(8'h00, rd, rs);
    cmp_resp(rs, RESP_SLVERR);
    axi_write(8'h00, 8'h5a, rs);
    cmp_resp(rs, RESP_SLVERR);
    axi_write(IDX_IRQ_MASK, 8'h01, rs);
    axi_write(IDX_OE_POL, 8'hf0, rs);
    // each prescale code with random reload and duties
    for (int p = 0; p < 8; p++) begin
      rl = 8'hf8 + 8'({$random(seed)} % 7);
      axi_write(IDX_RELOAD, rl, rs);
      for (int c = 0; c < 4; c++) begin
        dt[c] = rl + 8'({$random(seed)} % (255 - rl));
        axi_write(IDX_DUTY0 - 8'(c), dt[c], rs);
      end
      // force reload starts each pass at the reload value, not at a stale count
      axi_write(IDX_CSR, {1'b0, 3'(p), 4'b1100}, rs);
      per = (256 - rl) << p;
      repeat (3 * per + 20) @(posedge clk);
      for (int c = 0; c < 4; c++) begin
        cmp_len(32'(period_len[c]), 32'(per));
        cmp_len(32'(high_len[c]), (32'(dt[c]) - 32'(rl) + 32'h1) << p);
        cmp_len(rise_at[c], rise_at[0]);
      end
    end
    cmp_byte({7'h0, irq}, 8'h00);
    // counter written while it runs slowly
    axi_write(IDX_CAR, 8'h10, rs);
    axi_read(IDX_CAR, rd, rs);
    cmp_byte({7'h0, rd == 8'h10 || rd == 8'h11}, 8'h01);
    // flag left over from the passes reads set, then the read clears it
    axi_read(IDX_CSR, rd, rs);
    cmp_byte(rd, 8'h79);
    axi_write(IDX_CSR, 8'h0a, rs);
    per = 0;
    while (irq !== 1'b1 && per < 600) begin
      @(posedge clk);
      per++;
    end
    cmp_byte({7'h0, irq}, 8'h01);
    // stop, then the flag clears on its first read
    axi_write(IDX_CSR, 8'h02, rs);
    axi_read(IDX_CSR, rd, rs);
    cmp_byte(rd, 8'h03);
    axi_read(IDX_CSR, rd, rs);
    cmp_byte(rd, 8'h02);
    repeat (2) @(posedge clk);
    cmp_byte({7'h0, irq}, 8'h00);
    axi_read(IDX_CAR, rd, rs);
    axi_read(IDX_CAR, rd2, rs);
    cmp_byte(rd2, rd);
    axi_write(IDX_RELOAD, 8'h40, rs);
    axi_write(IDX_CSR, 8'h04, rs);
    axi_read(IDX_CAR, rd, rs);
    cmp_byte(rd, 8'h40);
    // frozen counter below every compare: pins follow polarity and enable
    repeat (2) @(posedge clk);
    cmp_byte({4'h0, pwm}, 8'h0f);
    axi_write(IDX_OE_POL, 8'hf5, rs);
    repeat (2) @(posedge clk);
    cmp_byte({4'h0, pwm}, 8'h0a);
    axi_write(IDX_OE_POL, 8'h35, rs);
    repeat (2) @(posedge clk);
    cmp_byte({4'h0, pwm}, 8'h02);
    // masked interrupt stays low while the flag is set
    axi_write(IDX_IRQ_MASK, 8'h00, rs);
    axi_write(IDX_RELOAD, 8'hf0, rs);
    axi_write(IDX_CSR, 8'h0a, rs);
    repeat (300) @(posedge clk);
    cmp_byte({7'h0, irq}, 8'h00);
    axi_read(IDX_CSR, rd, rs);
    cmp_byte(rd & 8'h01, 8'h01);
    // a write without the low strobe is answered but leaves the register alone
    wstrb <= 4'h0;
    axi_write(IDX_RELOAD, 8'h11, rs);
    cmp_resp(rs, RESP_OKAY);
    wstrb <= 4'hf;
    axi_read(IDX_RELOAD, rd, rs);
    cmp_byte(rd, 8'hf0);
    // a second reset in mid-run brings duty back to zero and the pins low
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    axi_read(IDX_DUTY0, rd, rs);
    cmp_byte(rd, 8'h00);
    cmp_byte({4'h0, pwm}, 8'h00);
    complete_run();
  end

  // watchdog well beyond the longest prescale pass
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
